/* pkg/uart_data_port_defs.vh */
// Constants for the serial data port: addresses, fields, reset values, timing
`ifndef UART_DATA_PORT_DEFS_VH
`define UART_DATA_PORT_DEFS_VH
`define ADDR_DATA          32'h50001000
`define ADDR_DIV_HIGH      32'h50001004
`define ADDR_FIFO_CTRL     32'h50001008
`define ADDR_LINE_CTRL     32'h5000100C
`define ADDR_LINE_STATUS   32'h50001014
`define ADDR_IRQ_STATUS    32'h50001020
`define ADDR_IRQ_ENABLE    32'h50001024
`define ADDR_IRQ_CLEAR     32'h50001028
`define LCR_DIV_ACCESS_BIT 7
`define FCR_FIFO_EN_BIT    0
`define LSR_DATA_READY_BIT 0
`define LSR_OVERRUN_BIT    1
`define LSR_THR_EMPTY_BIT  5
`define LSR_TX_IDLE_BIT    6
`define IRQ_RX_BIT         0
`define IRQ_OVERRUN_BIT    1
`define IRQ_TX_EMPTY_BIT   2
`define FIFO_DEPTH         16
`define OVERSAMPLE         16
`define DIV_RESET          16'h0000
`define DATA_RESET         8'h00
`endif

/* rtl/uart_rx_tx_data_port.v */
// Serial transceiver data port with rx/tx holding buffers, FIFOs and baud divisor
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_data_port_defs.vh"
module uart_rx_tx_data_port (
    input  wire        i_ref_clk,
    input  wire        i_sys_rst,
    input  wire [31:0] i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire        i_rx_line,
    output reg  [15:0] o_rdata,
    output reg         o_tx_line,
    output reg         o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    localparam TX_IDLE  = 2'd0;
    localparam TX_START = 2'd1;
    localparam TX_DATA  = 2'd2;
    localparam TX_STOP  = 2'd3;
    localparam [31:0] DEPTH_FULL = `FIFO_DEPTH;

    function is_addr;
        input [31:0] a;
        input [31:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    reg  [7:0]  div_low_reg;
    reg  [7:0]  div_high_reg;
    reg         fifo_en_reg;
    reg  [7:0]  line_ctrl_reg;
    reg  [2:0]  irq_stat_reg;
    reg  [2:0]  irq_en_reg;
    reg         overrun_reg;
    reg  [7:0]  rx_mem [0:`FIFO_DEPTH-1];
    reg  [7:0]  tx_mem [0:`FIFO_DEPTH-1];
    reg  [3:0]  rx_rd_reg;
    reg  [3:0]  rx_wr_reg;
    reg  [4:0]  rx_cnt_reg;
    reg  [3:0]  tx_rd_reg;
    reg  [3:0]  tx_wr_reg;
    reg  [4:0]  tx_cnt_reg;
    reg         rx_s1_reg;
    reg         rx_s2_reg;
    reg  [15:0] baud_cnt_reg;
    reg         tick_reg;
    reg  [1:0]  tx_state_reg;
    reg  [3:0]  tx_os_reg;
    reg  [2:0]  tx_bit_reg;
    reg  [7:0]  tx_shift_reg;
    reg  [1:0]  rx_state_reg;
    reg  [3:0]  rx_os_reg;
    reg  [2:0]  rx_bit_reg;
    reg  [7:0]  rx_shift_reg;
    reg         rx_done_reg;

    wire [15:0] divisor   = {div_high_reg, div_low_reg};
    wire        div_acc   = line_ctrl_reg[`LCR_DIV_ACCESS_BIT];
    wire        data_sel  = is_addr(i_addr, `ADDR_DATA);
    wire [4:0]  tx_cap    = fifo_en_reg ? DEPTH_FULL[4:0] : 5'd1;
    wire        tx_full   = (tx_cnt_reg >= tx_cap);
    wire        thr_empty = (tx_cnt_reg == 5'd0);
    wire        data_rdy  = (rx_cnt_reg != 5'd0);
    wire        rx_full   = fifo_en_reg ? (rx_cnt_reg == DEPTH_FULL[4:0]) : data_rdy;
    wire        rx_pop    = i_rd && data_sel && !div_acc && data_rdy;
    wire        tx_wr     = i_wr && data_sel && !div_acc;
    wire        tx_load   = (tx_state_reg == TX_IDLE) && tick_reg && !thr_empty;
    // Single-buffer mode overwrites the held byte in place
    wire        tx_repl   = tx_wr && !fifo_en_reg && !thr_empty && !tx_load;
    // A write meeting the outgoing load refills the slot instead of vanishing
    wire        tx_push   = tx_wr &&
                            (!tx_full || (!fifo_en_reg && tx_load));
    wire        rx_push   = rx_done_reg && !(fifo_en_reg && rx_full && !rx_pop);
    wire        rx_ovr    = rx_done_reg && rx_full && !rx_pop;
    wire        rx_over   = rx_push && !fifo_en_reg && rx_full && !rx_pop;

    ////////////////////////////////////////////////////////////////////////////
    // Baud tick at 16x; zero divisor holds everything still
    always @(posedge i_ref_clk) begin
        if (i_sys_rst || divisor == 16'h0000) begin
            baud_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else if (baud_cnt_reg >= divisor - 16'h0001) begin
            baud_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b1;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
            tick_reg     <= 1'b0;
        end
    end

    always @(posedge i_ref_clk) begin
        rx_s1_reg <= i_rx_line;
        rx_s2_reg <= rx_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; upper data byte is simply not looked at
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_low_reg   <= 8'h00;
            div_high_reg  <= 8'h00;
            fifo_en_reg   <= 1'b0;
            line_ctrl_reg <= 8'h00;
            irq_en_reg    <= 3'h0;
        end else if (i_wr) begin
            if (data_sel && div_acc) begin
                div_low_reg <= i_wdata[7:0];
            end else if (is_addr(i_addr, `ADDR_DIV_HIGH) && div_acc) begin
                div_high_reg <= i_wdata[7:0];
            end else if (is_addr(i_addr, `ADDR_FIFO_CTRL)) begin
                fifo_en_reg <= i_wdata[`FCR_FIFO_EN_BIT];
            end else if (is_addr(i_addr, `ADDR_LINE_CTRL)) begin
                line_ctrl_reg <= i_wdata[7:0];
            end else if (is_addr(i_addr, `ADDR_IRQ_ENABLE)) begin
                irq_en_reg <= i_wdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit storage; depth 1 when FIFOs are off
    always @(posedge i_ref_clk) begin
        if (i_sys_rst || (i_wr && is_addr(i_addr, `ADDR_FIFO_CTRL))) begin
            tx_rd_reg  <= 4'h0;
            tx_wr_reg  <= 4'h0;
            tx_cnt_reg <= 5'h00;
        end else begin
            if (tx_repl) begin
                tx_mem[tx_rd_reg] <= i_wdata[7:0];
            end else if (tx_push) begin
                tx_mem[tx_wr_reg] <= i_wdata[7:0];
                tx_wr_reg <= tx_wr_reg + 4'h1;
            end
            if (tx_load) begin
                tx_rd_reg <= tx_rd_reg + 4'h1;
            end
            tx_cnt_reg <= tx_cnt_reg + {4'h0, tx_push && !tx_repl} - {4'h0, tx_load};
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            tx_state_reg <= TX_IDLE;
            tx_os_reg    <= 4'h0;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= `DATA_RESET;
            o_tx_line    <= 1'b1;
        end else if (tick_reg) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (!thr_empty) begin
                        tx_shift_reg <= tx_mem[tx_rd_reg];
                        tx_state_reg <= TX_START;
                        tx_os_reg    <= 4'h0;
                        o_tx_line    <= 1'b0;
                    end
                end
                TX_START: begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (tx_os_reg == 4'hF) begin
                        tx_state_reg <= TX_DATA;
                        tx_bit_reg   <= 3'h0;
                        o_tx_line    <= tx_shift_reg[0];
                    end
                end
                TX_DATA: begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (tx_os_reg == 4'hF) begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg   <= tx_bit_reg + 3'h1;
                        if (tx_bit_reg == 3'h7) begin
                            tx_state_reg <= TX_STOP;
                            o_tx_line    <= 1'b1;
                        end else begin
                            o_tx_line <= tx_shift_reg[1];
                        end
                    end
                end
                default: begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (tx_os_reg == 4'hF) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver samples mid-bit at 16x oversampling; no framing check
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rx_state_reg <= TX_IDLE;
            rx_os_reg    <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= `DATA_RESET;
            rx_done_reg  <= 1'b0;
        end else begin
            rx_done_reg <= 1'b0;
            if (tick_reg) begin
                case (rx_state_reg)
                    TX_IDLE: begin
                        rx_os_reg <= 4'h0;
                        if (!rx_s2_reg) begin
                            rx_state_reg <= TX_START;
                        end
                    end
                    TX_START: begin
                        rx_os_reg <= rx_os_reg + 4'h1;
                        if (rx_os_reg == 4'h7) begin
                            rx_os_reg    <= 4'h0;
                            rx_bit_reg   <= 3'h0;
                            rx_state_reg <= rx_s2_reg ? TX_IDLE : TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        rx_os_reg <= rx_os_reg + 4'h1;
                        if (rx_os_reg == 4'hF) begin
                            rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
                            rx_bit_reg   <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == 3'h7) begin
                                rx_state_reg <= TX_STOP;
                            end
                        end
                    end
                    default: begin
                        rx_os_reg <= rx_os_reg + 4'h1;
                        if (rx_os_reg == 4'hF) begin
                            rx_state_reg <= TX_IDLE;
                            rx_done_reg  <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Receive storage; in single mode the slot is rewritten in place
    always @(posedge i_ref_clk) begin
        if (i_sys_rst || (i_wr && is_addr(i_addr, `ADDR_FIFO_CTRL))) begin
            rx_rd_reg  <= 4'h0;
            rx_wr_reg  <= 4'h0;
            rx_cnt_reg <= 5'h00;
        end else begin
            if (rx_over) begin
                rx_mem[rx_rd_reg] <= rx_shift_reg;
            end else if (rx_push) begin
                rx_mem[rx_wr_reg] <= rx_shift_reg;
                rx_wr_reg <= rx_wr_reg + 4'h1;
            end
            if (rx_pop) begin
                rx_rd_reg <= rx_rd_reg + 4'h1;
            end
            rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push && !rx_over} - {4'h0, rx_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky overrun and interrupt status; set wins over clear
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            overrun_reg  <= 1'b0;
            irq_stat_reg <= 3'h0;
            o_irq        <= 1'b0;
        end else begin
            if (rx_ovr) begin
                overrun_reg <= 1'b1;
            end else if (i_rd && is_addr(i_addr, `ADDR_LINE_STATUS)) begin
                overrun_reg <= 1'b0;
            end
            irq_stat_reg <= (irq_stat_reg &
                             ~((i_wr && is_addr(i_addr, `ADDR_IRQ_CLEAR)) ? i_wdata[2:0] : 3'h0))
                            | {tx_load && tx_cnt_reg == 5'd1, rx_ovr, rx_done_reg};
            o_irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe; upper byte zero
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (data_sel) begin
                // Empty buffer reads zero, same as after reset
                o_rdata <= {8'h00, div_acc ? div_low_reg :
                            (data_rdy ? rx_mem[rx_rd_reg] : 8'h00)};
            end else if (is_addr(i_addr, `ADDR_DIV_HIGH)) begin
                o_rdata <= {8'h00, div_acc ? div_high_reg : 8'h00};
            end else if (is_addr(i_addr, `ADDR_FIFO_CTRL)) begin
                o_rdata <= {15'h0000, fifo_en_reg};
            end else if (is_addr(i_addr, `ADDR_LINE_CTRL)) begin
                o_rdata <= {8'h00, line_ctrl_reg};
            end else if (is_addr(i_addr, `ADDR_LINE_STATUS)) begin
                o_rdata <= {9'h000, thr_empty && tx_state_reg == TX_IDLE, thr_empty,
                            3'h0, overrun_reg, data_rdy};
            end else if (is_addr(i_addr, `ADDR_IRQ_STATUS)) begin
                o_rdata <= {13'h0000, irq_stat_reg};
            end else if (is_addr(i_addr, `ADDR_IRQ_ENABLE)) begin
                o_rdata <= {13'h0000, irq_en_reg};
            end else begin
                o_rdata <= 16'h0000;
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // uart_rx_tx_data_port
`default_nettype wire

/* testbench/uart_port_checker_assertions.sv */
// Checker for the serial data port: bus answer, divisor access, line timing
`timescale 1ns/1ps
`default_nettype none
`include "uart_data_port_defs.vh"
module uart_port_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic [31:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_rx_line,
    input wire logic [15:0] o_rdata,
    input wire logic        o_tx_line,
    input wire logic        o_irq
);
    // Shadow of what software wrote; the design's own state is not visible here
    logic       div_access_reg;
    logic [7:0] div_low_reg;
    logic [7:0] div_high_reg;
    logic [2:0] en_reg;
    wire        div_zero = (div_low_reg == 8'h00) && (div_high_reg == 8'h00);
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_access_reg <= 1'b0;
            div_low_reg    <= 8'h00;
            div_high_reg   <= 8'h00;
            en_reg         <= 3'h0;
        end else if (i_wr) begin
            if (i_addr == `ADDR_LINE_CTRL)
                div_access_reg <= i_wdata[7];
            if (i_addr == `ADDR_DATA && div_access_reg)
                div_low_reg <= i_wdata[7:0];
            if (i_addr == `ADDR_DIV_HIGH && div_access_reg)
                div_high_reg <= i_wdata[7:0];
            if (i_addr == `ADDR_IRQ_ENABLE)
                en_reg <= i_wdata[2:0];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
////////////////////////////////////////////////////////////
    a_reset_idle_line: assert property ($fell(i_sys_rst) |-> o_tx_line && !o_irq)
        else $error("line or irq not idle after reset");
    a_upper_byte_zero: assert property (o_rdata[15:8] == 8'h00)
        else $error("upper read byte not zero");
    a_answer_only_once: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    a_divisor_low_readback: assert property (i_rd && i_addr == `ADDR_DATA && div_access_reg
        |=> o_rdata == {8'h00, $past(div_low_reg)})
        else $error("divisor low byte read back wrong");
    a_start_bit_low: assert property ($fell(o_tx_line) |-> !o_tx_line [*8])
        else $error("start bit too short");
    a_bit_hold_time: assert property ($changed(o_tx_line) |=> $stable(o_tx_line) [*8])
        else $error("serial bit too short");
    a_quiet_zero_divisor: assert property (div_zero [*2] ##0 o_tx_line |=> o_tx_line)
        else $error("traffic with zero divisor");
    a_irq_needs_enable: assert property (o_irq |-> en_reg != 3'h0 || $past(en_reg) != 3'h0)
        else $error("irq high with all enables clear");
    c_divisor_read: cover property (i_rd && i_addr == `ADDR_DATA && div_access_reg);
    c_frame_start: cover property ($fell(o_tx_line));
    c_irq_raise: cover property ($rose(o_irq));
endmodule // uart_port_checker
bind uart_rx_tx_data_port uart_port_checker checker_inst (
    .i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_rx_line, .o_rdata, .o_tx_line, .o_irq
);
`default_nettype wire

/* testbench/uart_peer.sv */
// Remote serial peer: drives frames in, captures frames out
`timescale 1ns/1ps
`default_nettype none
module uart_peer #(
    parameter int DIV = 1
) (
    input  wire logic i_ref_clk,
    input  wire logic i_line,
    output var  logic o_line
);
    localparam int BITLEN = 16 * DIV;
    logic [7:0] got[$];
    logic [7:0] shift_reg;
    initial o_line = 1'b1;
////////////////////////////////////////////////////////////
    // Start, 8 data bits LSB first, stop; line idles high between frames
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BITLEN) @(posedge i_ref_clk);
        end
    endtask
    // Samples mid-bit; stop bit not judged, idle looks the same
    always begin
        @(negedge i_line);
        repeat (BITLEN / 2) @(posedge i_ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITLEN) @(posedge i_ref_clk);
            shift_reg[i] = i_line;
        end
        repeat (BITLEN) @(posedge i_ref_clk);
        got.push_back(shift_reg);
    end
endmodule // uart_peer
`default_nettype wire

/* testbench/uart_rx_tx_data_port_test.sv */
// Self-checking bench for the serial data port
`timescale 1ns/1ps
`default_nettype none
`include "uart_data_port_defs.vh"
module uart_rx_tx_data_port_test;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [31:0] i_addr    = 32'h00000000;
    logic [15:0] i_wdata   = 16'h0000;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    wire         i_rx_line;
    wire  [15:0] o_rdata;
    wire         o_tx_line;
    wire         o_irq;
    int          fails     = 0;
    int          tests_run = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    uart_rx_tx_data_port uut (.i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .i_rx_line, .o_rdata, .o_tx_line, .o_irq);
    uart_peer #(.DIV(1)) peer (.i_ref_clk, .i_line(o_tx_line), .o_line(i_rx_line));
////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [31:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata & m, e);
    endtask
    task automatic set_div(input logic [15:0] d);
        wr(`ADDR_LINE_CTRL, 16'h0080);
        wr(`ADDR_DATA, d);
        wr(`ADDR_LINE_CTRL, 16'h0000);
    endtask
    // Waits for n frames, then lingers to catch any extra one
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (peer.got.size() < n && k < 5000) begin
            @(posedge i_ref_clk);
            k++;
        end
        if (peer.got.size() < n) begin
            fails++;
            $display("wrong value at %0t: frames missing at timeout", $time);
            stop_test();
        end else begin
            repeat (300) @(posedge i_ref_clk);
            chk(16'(peer.got.size()), 16'(n));
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_ref_clk);
        #1 chk({15'h0, o_irq}, {15'h0, e});
    endtask
////////////////////////////////////////////////////////////
    task automatic t_idle();
        rdc(`ADDR_DATA, 16'hFFFF, 16'h0000);
        rdc(`ADDR_LINE_STATUS, 16'h0061, 16'h0060);
        rdc(32'h50001010, 16'hFFFF, 16'h0000);
        wr(`ADDR_DATA, 16'h00A5);
        repeat (300) @(posedge i_ref_clk);
        chk(16'(peer.got.size()), 16'h0000);
    endtask
    task automatic t_divisor();
        wr(`ADDR_LINE_CTRL, 16'h0080);
        wr(`ADDR_DATA, 16'hFF01);
        wr(`ADDR_DIV_HIGH, 16'h0000);
        rdc(`ADDR_DATA, 16'hFFFF, 16'h0001);
        wr(`ADDR_LINE_CTRL, 16'h0000);
        wait_tx(1);
        chk({8'h00, peer.got[0]}, 16'h00A5);
    endtask
    task automatic t_tx_single();
        peer.got.delete();
        wr(`ADDR_DATA, 16'h0011);
        repeat (4) @(posedge i_ref_clk);
        wr(`ADDR_DATA, 16'h0022);
        rdc(`ADDR_LINE_STATUS, 16'h0020, 16'h0000);
        wr(`ADDR_DATA, 16'h0033);
        wait_tx(2);
        chk({8'h00, peer.got[0]}, 16'h0011);
        chk({8'h00, peer.got[1]}, 16'h0033);
    endtask
    task automatic t_rx_single();
        peer.send(8'h3C);
        peer.send(8'hC3);
        rdc(`ADDR_LINE_STATUS, 16'h0003, 16'h0003);
        rdc(`ADDR_IRQ_STATUS, 16'h0002, 16'h0002);
        rdc(`ADDR_DATA, 16'hFFFF, 16'h00C3);
        rdc(`ADDR_LINE_STATUS, 16'h0003, 16'h0000);
    endtask
    task automatic t_fifo_rx();
        wr(`ADDR_FIFO_CTRL, 16'h0001);
        for (int i = 0; i < 17; i++) peer.send(8'h40 + 8'(i));
        rdc(`ADDR_LINE_STATUS, 16'h0003, 16'h0003);
        for (int i = 0; i < 16; i++) rdc(`ADDR_DATA, 16'hFFFF, 16'h0040 + 16'(i));
        rdc(`ADDR_LINE_STATUS, 16'h0001, 16'h0000);
    endtask
    // Baud stopped so the transmit FIFO fills without draining
    task automatic t_fifo_tx();
        peer.got.delete();
        set_div(16'h0000);
        for (int i = 0; i < 17; i++) wr(`ADDR_DATA, 16'h0060 + 16'(i));
        set_div(16'h0001);
        repeat (8) @(posedge i_ref_clk);
        wait_tx(16);
        for (int i = 0; i < 16; i++) chk({8'h00, peer.got[i]}, 16'h0060 + 16'(i));
    endtask
    task automatic t_irq();
        wr(`ADDR_IRQ_CLEAR, 16'h0007);
        wr(`ADDR_IRQ_ENABLE, 16'h0001);
        irq_is(1'b0);
        peer.send(8'h5A);
        irq_is(1'b1);
        wr(`ADDR_IRQ_ENABLE, 16'h0000);
        irq_is(1'b0);
        wr(`ADDR_IRQ_ENABLE, 16'h0001);
        rdc(`ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
        wr(`ADDR_IRQ_CLEAR, 16'h0001);
        irq_is(1'b0);
        // Holding buffer drains into the shifter: empty event
        wr(`ADDR_IRQ_ENABLE, 16'h0004);
        wr(`ADDR_DATA, 16'h0077);
        irq_is(1'b1);
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_idle();
        t_divisor();
        t_tx_single();
        t_rx_single();
        t_fifo_rx();
        t_fifo_tx();
        t_irq();
        stop_test();
    end
endmodule // uart_rx_tx_data_port_test
`default_nettype wire
